// ### core/flash_bus_cycle.sv
/*
 * One asynchronous flash bus cycle, write or read, timed in system clocks.
 * Address and data are set up, chip select with write or output enable
 * strobe low, then released. Assumes dq_in is synchronous to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module flash_bus_cycle
	import flash_host_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic start,
	input wire flash_host_pkg::cyc_s cyc,
	input wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
	output flash_host_pkg::pins_s pins,
	output logic [flash_host_pkg::DATA_W-1:0] rdata,
	output logic done
);
	import flash_host_pkg::*;

	typedef enum logic [3:0] {
		E_IDLE = 4'h1,
		E_SETUP = 4'h2,
		E_STROBE = 4'h4,
		E_RECOV = 4'h8
	} bus_state_e;

	localparam logic [CNT_W-1:0] SETUP_END = CNT_W'(DATA_SETUP_CYC - 1);
	localparam logic [CNT_W-1:0] LOW_END = CNT_W'(STROBE_LOW_CYC - 1);
	localparam logic [CNT_W-1:0] READ_END = CNT_W'(READ_WAIT_CYC - 1);
	localparam logic [CNT_W-1:0] HIGH_END = CNT_W'(STROBE_HIGH_CYC - 1);

	bus_state_e state_r, state_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic is_read_r, is_read_nxt;
	pins_s pins_r, pins_nxt;
	logic [DATA_W-1:0] rdata_r, rdata_nxt;
	logic done_r, done_nxt;

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = CNT_W'(cnt_r + 1'b1);
		is_read_nxt = is_read_r;
		pins_nxt = pins_r;
		rdata_nxt = rdata_r;
		done_nxt = 1'b0;
		case (state_r)
			E_IDLE:
			begin
				cnt_nxt = '0;
				if (start)
				begin
					state_nxt = E_SETUP;
					is_read_nxt = cyc.is_read;
					pins_nxt.addr = cyc.addr;
					pins_nxt.dq_out = cyc.data;
					pins_nxt.dq_oe = ~cyc.is_read;
				end
			end
			E_SETUP:
			begin
				if (cnt_r == SETUP_END)
				begin
					state_nxt = E_STROBE;
					cnt_nxt = '0;
					pins_nxt.ce_n = 1'b0;
					pins_nxt.we_n = is_read_r;
					pins_nxt.oe_n = ~is_read_r;
				end
			end
			E_STROBE:
			begin
				if (cnt_r == (is_read_r ? READ_END : LOW_END))
				begin
					state_nxt = E_RECOV;
					cnt_nxt = '0;
					pins_nxt.ce_n = 1'b1;
					pins_nxt.we_n = 1'b1;
					pins_nxt.oe_n = 1'b1;
					if (is_read_r)
						rdata_nxt = dq_in;
				end
			end
			E_RECOV:
			begin
				if (cnt_r == HIGH_END)
				begin
					state_nxt = E_IDLE;
					cnt_nxt = '0;
					pins_nxt.dq_oe = 1'b0;
					done_nxt = 1'b1;
				end
			end
			default:
			begin
				state_nxt = E_IDLE;
				cnt_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r <= E_IDLE;
			cnt_r <= '0;
			is_read_r <= 1'b0;
			pins_r <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
			rdata_r <= '0;
			done_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			is_read_r <= is_read_nxt;
			pins_r <= pins_nxt;
			rdata_r <= rdata_nxt;
			done_r <= done_nxt;
		end
	end

	assign pins = pins_r;
	assign rdata = rdata_r;
	assign done = done_r;

endmodule : flash_bus_cycle

`default_nettype wire

// ### core/flash_command_decoder.sv
/*
 * Host controller that drives a parallel NOR flash command interface.
 * It accepts one operation at a time, checks it against the tracked device
 * mode, and plays out the matching bus-cycle series on the flash pins.
 * Assumes the flash pins and stream inputs are synchronous to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Every operation is issued as its exact defined address/data series.
// - After a broken series the host issues reset to restore array reads; this host never does so on its own, only on a requested reset operation.
// - All series cycles are writes unless marked read; command cycles have upper data byte zero.
// - Autoselect is AA/555, 55/2AA, 90/555 then reads of identification data.
// - Buffered program: unlock, 25 at sector, count minus one, then words.
// - All buffer words stay within the starting write-buffer page.
// - Buffer series spans 6 to 37 cycles, confirmed by 29 at sector.
// - Abort reset is AA, 55, F0 at 555; full series even in bypass.
// - Bypass entry AA, 55, 20; then two-cycle program and erase forms.
// - Leaving bypass needs 90 then 00 at any address.
// - Secured sector entry AA, 55, 88; exit unlock, 90, then 00.
module flash_command_decoder
	import flash_host_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic req_valid,
	input wire flash_host_pkg::req_s req,
	output logic req_ready,
	input wire logic wdata_valid,
	input wire logic [flash_host_pkg::DATA_W-1:0] wdata,
	output logic wdata_ready,
	output logic done,
	output logic refused,
	output logic rd_valid,
	output logic [flash_host_pkg::DATA_W-1:0] rdata,
	output flash_host_pkg::mode_e mode,
	output logic suspended,
	output logic flash_ce_n,
	output logic flash_we_n,
	output logic flash_oe_n,
	output logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
	output logic [flash_host_pkg::DATA_W-1:0] flash_dq_out,
	output logic flash_dq_oe,
	input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_in
);
	import flash_host_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_FETCH = 4'h2,
		ST_ISSUE = 4'h4,
		ST_WAIT = 4'h8
	} host_state_e;

	host_state_e state_r, state_nxt;
	req_s req_r, req_nxt;
	logic [STEP_W-1:0] step_r, step_nxt;
	logic [DATA_W-1:0] word_r, word_nxt;
	mode_e mode_r, mode_nxt;
	logic susp_r, susp_nxt;
	logic req_ready_r, req_ready_nxt;
	logic wdata_ready_r, wdata_ready_nxt;
	logic done_r, done_nxt;
	logic refused_r, refused_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic [DATA_W-1:0] rdata_r, rdata_nxt;
	logic start_r, start_nxt;

	cyc_s cyc;
	pins_s pins;
	logic [DATA_W-1:0] bus_rdata;
	logic bus_done;
	logic legal;
	logic page_fits;

	flash_seq_table u_table (
		.op(req_r.op),
		.mode(mode_r),
		.step(step_r),
		.req(req_r),
		.word(word_r),
		.cyc(cyc)
	);

	flash_bus_cycle u_bus (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.start(start_r),
		.cyc(cyc),
		.dq_in(flash_dq_in),
		.pins(pins),
		.rdata(bus_rdata),
		.done(bus_done)
	);

	assign page_fits = ({1'b0, req.addr[PAGE_W-1:0]} + {1'b0, req.wc}) <= {1'b0, PAGE_LAST};

	// Mode gating keeps the host from sending a series that the device would take as
	// out of order in its present mode, except bypass erases issued while suspended.
	always_comb
	begin
		legal = 1'b0;
		case (mode_r)
			MODE_BYPASS:
			begin
				legal = (req.op == OP_BYPASS_PROGRAM) || (req.op == OP_BYPASS_SECTOR_ERASE) ||
					(req.op == OP_BYPASS_CHIP_ERASE) || (req.op == OP_RESET) ||
					(req.op == OP_ABORT_RESET) || (req.op == OP_READ) ||
					(req.op == OP_SUSPEND) || (req.op == OP_RESUME && susp_r);
			end
			MODE_AUTOSELECT:
			begin
				legal = (req.op == OP_READ) || (req.op == OP_RESET) ||
					(req.op == OP_CFI) || (req.op == OP_AUTOSELECT);
			end
			MODE_SECURE:
			begin
				legal = (req.op == OP_READ) || (req.op == OP_PROGRAM) ||
					(req.op == OP_RESET) || (req.op == OP_SECURE_EXIT);
			end
			default:
			begin
				legal = (req.op != OP_BYPASS_PROGRAM) && (req.op != OP_BYPASS_SECTOR_ERASE) &&
					(req.op != OP_BYPASS_CHIP_ERASE) && (req.op != OP_SECURE_EXIT);
				if (req.op == OP_RESUME)
					legal = susp_r;
				if (susp_r && (req.op == OP_CHIP_ERASE || req.op == OP_SECTOR_ERASE))
					legal = 1'b0;
			end
		endcase
		if (req.op == OP_BUF_PROGRAM && !page_fits)
			legal = 1'b0;
	end

	always_comb
	begin
		state_nxt = state_r;
		req_nxt = req_r;
		step_nxt = step_r;
		word_nxt = word_r;
		mode_nxt = mode_r;
		susp_nxt = susp_r;
		req_ready_nxt = 1'b0;
		wdata_ready_nxt = 1'b0;
		done_nxt = 1'b0;
		refused_nxt = 1'b0;
		rd_valid_nxt = 1'b0;
		rdata_nxt = rdata_r;
		start_nxt = 1'b0;
		case (state_r)
			ST_IDLE:
			begin
				req_ready_nxt = 1'b1;
				if (req_valid && req_ready_r)
				begin
					req_ready_nxt = 1'b0;
					if (legal)
					begin
						req_nxt = req;
						step_nxt = '0;
						state_nxt = ST_FETCH;
					end
					else
					begin
						refused_nxt = 1'b1;
					end
				end
			end
			ST_FETCH:
			begin
				if (!cyc.from_stream)
				begin
					state_nxt = ST_ISSUE;
				end
				else if (wdata_valid && wdata_ready_r)
				begin
					word_nxt = wdata;
					state_nxt = ST_ISSUE;
				end
				else
				begin
					wdata_ready_nxt = 1'b1;
				end
			end
			ST_ISSUE:
			begin
				start_nxt = 1'b1;
				state_nxt = ST_WAIT;
			end
			ST_WAIT:
			begin
				if (bus_done)
				begin
					if (cyc.is_read)
					begin
						rdata_nxt = bus_rdata;
						rd_valid_nxt = 1'b1;
					end
					if (cyc.last)
					begin
						state_nxt = ST_IDLE;
						done_nxt = 1'b1;
						case (req_r.op)
							OP_RESET, OP_SECURE_EXIT:
								mode_nxt = MODE_ARRAY;
							OP_ABORT_RESET:
								mode_nxt = (mode_r == MODE_BYPASS) ? MODE_BYPASS : MODE_ARRAY;
							OP_AUTOSELECT:
								mode_nxt = MODE_AUTOSELECT;
							OP_BYPASS_ENTER:
								mode_nxt = MODE_BYPASS;
							OP_SECURE_ENTER:
								mode_nxt = MODE_SECURE;
							OP_SUSPEND:
								susp_nxt = 1'b1;
							OP_RESUME:
								susp_nxt = 1'b0;
							default:
								mode_nxt = mode_r;
						endcase
					end
					else
					begin
						step_nxt = STEP_W'(step_r + 1'b1);
						state_nxt = ST_FETCH;
					end
				end
			end
			default:
			begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r <= ST_IDLE;
			req_r <= '0;
			step_r <= '0;
			word_r <= '0;
			mode_r <= MODE_ARRAY;
			susp_r <= 1'b0;
			req_ready_r <= 1'b0;
			wdata_ready_r <= 1'b0;
			done_r <= 1'b0;
			refused_r <= 1'b0;
			rd_valid_r <= 1'b0;
			rdata_r <= '0;
			start_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			req_r <= req_nxt;
			step_r <= step_nxt;
			word_r <= word_nxt;
			mode_r <= mode_nxt;
			susp_r <= susp_nxt;
			req_ready_r <= req_ready_nxt;
			wdata_ready_r <= wdata_ready_nxt;
			done_r <= done_nxt;
			refused_r <= refused_nxt;
			rd_valid_r <= rd_valid_nxt;
			rdata_r <= rdata_nxt;
			start_r <= start_nxt;
		end
	end

	assign req_ready = req_ready_r;
	assign wdata_ready = wdata_ready_r;
	assign done = done_r;
	assign refused = refused_r;
	assign rd_valid = rd_valid_r;
	assign rdata = rdata_r;
	assign mode = mode_r;
	assign suspended = susp_r;
	assign flash_ce_n = pins.ce_n;
	assign flash_we_n = pins.we_n;
	assign flash_oe_n = pins.oe_n;
	assign flash_addr = pins.addr;
	assign flash_dq_out = pins.dq_out;
	assign flash_dq_oe = pins.dq_oe;

endmodule : flash_command_decoder

`default_nettype wire

// ### core/flash_host_pkg.sv
/*
 * Shared constants and types for the host-side controller of a parallel
 * NOR flash in 16-bit word mode: command codes, unlock addresses, timing
 * counts, operation and mode enumerations, and the carrier structs.
 * Assumes a single 20 MHz system clock.
 */
package flash_host_pkg;

	localparam int ADDR_W = 26;
	localparam int DATA_W = 16;
	localparam int WC_W = 5;
	localparam int STEP_W = 6;
	localparam int CNT_W = 4;
	localparam int SECTOR_LSB = 16;
	localparam int PAGE_W = 5;

	localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 26'h0000555;
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 26'h00002AA;
	localparam logic [ADDR_W-1:0] CFI_ADDR = 26'h0000055;
	localparam logic [ADDR_W-1:0] ANY_ADDR = 26'h0000000;

	localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 16'h00AA;
	localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 16'h0055;
	localparam logic [DATA_W-1:0] CMD_RESET = 16'h00F0;
	localparam logic [DATA_W-1:0] CMD_AUTOSELECT = 16'h0090;
	localparam logic [DATA_W-1:0] CMD_CFI = 16'h0098;
	localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00A0;
	localparam logic [DATA_W-1:0] CMD_BUF_LOAD = 16'h0025;
	localparam logic [DATA_W-1:0] CMD_BUF_CONFIRM = 16'h0029;
	localparam logic [DATA_W-1:0] CMD_BYPASS = 16'h0020;
	localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080;
	localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 16'h0030;
	localparam logic [DATA_W-1:0] CMD_CHIP_ERASE = 16'h0010;
	localparam logic [DATA_W-1:0] CMD_SUSPEND = 16'h00B0;
	localparam logic [DATA_W-1:0] CMD_RESUME = 16'h0030;
	localparam logic [DATA_W-1:0] CMD_SECURE = 16'h0088;
	localparam logic [DATA_W-1:0] CMD_EXIT = 16'h0090;
	localparam logic [DATA_W-1:0] CMD_EXIT_DATA = 16'h0000;

	localparam logic [STEP_W-1:0] BUF_DATA_STEP = 6'h04;
	localparam logic [PAGE_W-1:0] PAGE_LAST = 5'h1F;

	localparam int CLK_PERIOD_NS = 50;
	localparam int STROBE_LOW_NS = 35;
	localparam int STROBE_HIGH_NS = 30;
	localparam int DATA_SETUP_NS = 30;
	localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DATA_SETUP_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_WAIT_CYC = 4;

	typedef enum logic [4:0] {
		OP_READ = 5'h00,
		OP_RESET = 5'h01,
		OP_AUTOSELECT = 5'h02,
		OP_CFI = 5'h03,
		OP_PROGRAM = 5'h04,
		OP_BUF_PROGRAM = 5'h05,
		OP_ABORT_RESET = 5'h06,
		OP_BYPASS_ENTER = 5'h07,
		OP_BYPASS_PROGRAM = 5'h08,
		OP_BYPASS_SECTOR_ERASE = 5'h09,
		OP_BYPASS_CHIP_ERASE = 5'h0A,
		OP_CHIP_ERASE = 5'h0B,
		OP_SECTOR_ERASE = 5'h0C,
		OP_SUSPEND = 5'h0D,
		OP_RESUME = 5'h0E,
		OP_SECURE_ENTER = 5'h0F,
		OP_SECURE_EXIT = 5'h10
	} op_e;

	typedef enum logic [1:0] {
		MODE_ARRAY = 2'h0,
		MODE_AUTOSELECT = 2'h1,
		MODE_BYPASS = 2'h2,
		MODE_SECURE = 2'h3
	} mode_e;

	typedef struct packed {
		op_e op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [WC_W-1:0] wc;
	} req_s;

	typedef struct packed {
		logic is_read;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic last;
		logic from_stream;
	} cyc_s;

	typedef struct packed {
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq_out;
		logic dq_oe;
	} pins_s;

endpackage : flash_host_pkg

// ### core/flash_seq_table.sv
/*
 * Combinational table that turns an operation, the current device mode and
 * a step index into one bus cycle: read or write, address, data, last flag.
 * Assumes the caller holds op, mode, step and the request stable.
 */
`timescale 1ns/1ps
`default_nettype none

module flash_seq_table
	import flash_host_pkg::*;
(
	input wire flash_host_pkg::op_e op,
	input wire flash_host_pkg::mode_e mode,
	input wire logic [flash_host_pkg::STEP_W-1:0] step,
	input wire flash_host_pkg::req_s req,
	input wire logic [flash_host_pkg::DATA_W-1:0] word,
	output flash_host_pkg::cyc_s cyc
);
	import flash_host_pkg::*;

	logic [ADDR_W-1:0] sector_addr;
	logic [STEP_W-1:0] buf_idx;
	logic [STEP_W-1:0] buf_last;
	logic [ADDR_W-1:0] buf_addr;

	assign sector_addr = {req.addr[ADDR_W-1:SECTOR_LSB], {SECTOR_LSB{1'b0}}};
	assign buf_idx = STEP_W'(step - BUF_DATA_STEP);
	assign buf_last = STEP_W'(BUF_DATA_STEP + STEP_W'(req.wc));
	assign buf_addr = {req.addr[ADDR_W-1:PAGE_W], PAGE_W'(req.addr[PAGE_W-1:0] + buf_idx[PAGE_W-1:0])};

	always_comb
	begin
		cyc = '0;
		cyc.addr = UNLOCK_ADDR1;
		cyc.data = CMD_UNLOCK1;
		if (step == 6'h01 || step == 6'h04)
		begin
			cyc.addr = UNLOCK_ADDR2;
			cyc.data = CMD_UNLOCK2;
		end
		case (op)
			OP_READ:
			begin
				cyc.is_read = 1'b1;
				cyc.addr = req.addr;
				cyc.last = 1'b1;
			end
			OP_RESET, OP_SECURE_EXIT:
			begin
				if (mode == MODE_BYPASS && op == OP_RESET)
				begin
					cyc.addr = ANY_ADDR;
					cyc.data = (step == 6'h00) ? CMD_EXIT : CMD_EXIT_DATA;
					cyc.last = (step == 6'h01);
				end
				else if (mode == MODE_SECURE || op == OP_SECURE_EXIT)
				begin
					if (step == 6'h02)
						cyc.data = CMD_EXIT;
					if (step == 6'h03)
					begin
						cyc.addr = ANY_ADDR;
						cyc.data = CMD_EXIT_DATA;
						cyc.last = 1'b1;
					end
				end
				else
				begin
					cyc.addr = ANY_ADDR;
					cyc.data = CMD_RESET;
					cyc.last = 1'b1;
				end
			end
			OP_AUTOSELECT:
			begin
				if (step == 6'h02)
					cyc.data = CMD_AUTOSELECT;
				if (step == 6'h03)
				begin
					cyc.is_read = 1'b1;
					cyc.addr = req.addr;
					cyc.last = 1'b1;
				end
			end
			OP_CFI:
			begin
				cyc.addr = CFI_ADDR;
				cyc.data = CMD_CFI;
				cyc.last = 1'b1;
			end
			OP_PROGRAM:
			begin
				if (step == 6'h02)
					cyc.data = CMD_PROGRAM;
				if (step == 6'h03)
				begin
					cyc.addr = req.addr;
					cyc.data = req.data;
					cyc.last = 1'b1;
				end
			end
			OP_BUF_PROGRAM:
			begin
				if (step == 6'h02)
				begin
					cyc.addr = sector_addr;
					cyc.data = CMD_BUF_LOAD;
				end
				else if (step == 6'h03)
				begin
					cyc.addr = sector_addr;
					cyc.data = DATA_W'(req.wc);
				end
				else if (step >= BUF_DATA_STEP && step <= buf_last)
				begin
					cyc.addr = buf_addr;
					cyc.data = word;
					cyc.from_stream = 1'b1;
				end
				else if (step > buf_last)
				begin
					cyc.addr = sector_addr;
					cyc.data = CMD_BUF_CONFIRM;
					cyc.last = 1'b1;
				end
			end
			OP_ABORT_RESET:
			begin
				if (step == 6'h02)
				begin
					cyc.data = CMD_RESET;
					cyc.last = 1'b1;
				end
			end
			OP_BYPASS_ENTER:
			begin
				if (step == 6'h02)
				begin
					cyc.data = CMD_BYPASS;
					cyc.last = 1'b1;
				end
			end
			OP_BYPASS_PROGRAM:
			begin
				cyc.addr = (step == 6'h00) ? ANY_ADDR : req.addr;
				cyc.data = (step == 6'h00) ? CMD_PROGRAM : req.data;
				cyc.last = (step == 6'h01);
			end
			OP_BYPASS_SECTOR_ERASE, OP_BYPASS_CHIP_ERASE:
			begin
				cyc.addr = ANY_ADDR;
				cyc.data = CMD_ERASE_SETUP;
				if (step == 6'h01)
				begin
					cyc.addr = (op == OP_BYPASS_SECTOR_ERASE) ? sector_addr : ANY_ADDR;
					cyc.data = (op == OP_BYPASS_SECTOR_ERASE) ? CMD_SECTOR_ERASE : CMD_CHIP_ERASE;
					cyc.last = 1'b1;
				end
			end
			OP_CHIP_ERASE, OP_SECTOR_ERASE:
			begin
				if (step == 6'h02)
					cyc.data = CMD_ERASE_SETUP;
				if (step == 6'h05)
				begin
					cyc.addr = (op == OP_SECTOR_ERASE) ? sector_addr : UNLOCK_ADDR1;
					cyc.data = (op == OP_SECTOR_ERASE) ? CMD_SECTOR_ERASE : CMD_CHIP_ERASE;
					cyc.last = 1'b1;
				end
			end
			OP_SUSPEND, OP_RESUME:
			begin
				cyc.addr = ANY_ADDR;
				cyc.data = (op == OP_SUSPEND) ? CMD_SUSPEND : CMD_RESUME;
				cyc.last = 1'b1;
			end
			OP_SECURE_ENTER:
			begin
				if (step == 6'h02)
				begin
					cyc.data = CMD_SECURE;
					cyc.last = 1'b1;
				end
			end
			default:
			begin
				cyc.last = 1'b1;
			end
		endcase
	end

endmodule : flash_seq_table

`default_nettype wire

// ### verification/flash_cmd_props.sv
/* Checker for the flash command decoder: pin and handshake relations.
   Assumes one clock domain and the top module's port names. */
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_props
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic done,
	input wire logic refused,
	input wire logic rd_valid,
	input wire logic suspended,
	input wire logic flash_ce_n,
	input wire logic flash_we_n,
	input wire logic flash_oe_n,
	input wire logic [25:0] flash_addr,
	input wire logic [15:0] flash_dq_out,
	input wire logic flash_dq_oe
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	a_write_drive: assert property (!flash_we_n |-> flash_oe_n && flash_dq_oe && !flash_ce_n)
		else $error("write strobe without drive");
	a_read_float: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n && !flash_ce_n)
		else $error("read strobe while driving");
	a_latch_stable: assert property (!flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr) && $stable(flash_dq_out))
		else $error("address or data moved under strobe");
	a_data_setup: assert property ($fell(flash_we_n) |-> $past(flash_dq_oe))
		else $error("data not set up before strobe");
	a_refuse_take: assert property (refused |-> $past(req_valid) && $past(req_ready))
		else $error("refusal without a request");
	a_refuse_quiet: assert property (refused |-> flash_ce_n && !done)
		else $error("refused request touched pins");
	a_done_pulse: assert property (done |=> !done)
		else $error("done longer than one cycle");
	a_rdval_done: assert property (rd_valid |-> done)
		else $error("read data without done");
	a_idle_quiet: assert property (req_ready |-> flash_ce_n && flash_we_n)
		else $error("pins active while idle");
	a_ready_back: assert property (done |-> ##[1:2] req_ready)
		else $error("ready not back after done");
	a_suspend_cause: assert property ($changed(suspended) |-> done || $past(done))
		else $error("suspend flag moved without an operation");
endmodule : flash_cmd_props
bind flash_command_decoder flash_cmd_props u_props (.sys_clk(sys_clk), .arst_n(arst_n),
	.req_valid(req_valid), .req_ready(req_ready), .done(done), .refused(refused),
	.rd_valid(rd_valid), .suspended(suspended), .flash_ce_n(flash_ce_n),
	.flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .flash_addr(flash_addr),
	.flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));
`default_nettype wire

// ### verification/flash_dev_model.sv
/* Flash device stand-in: logs each write cycle, decodes commands, answers reads.
   Assumes the host pins change synchronously to sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
#(
	// The identity value is arbitrary.
	parameter logic [15:0] MAKER_ID = 16'h00C5
)
(
	input wire logic sys_clk,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [25:0] addr,
	input wire logic [15:0] dq_out,
	input wire logic dq_oe,
	output logic [15:0] dq_in
);
	logic [41:0] wlog[$];
	logic [15:0] mem[256];
	logic [15:0] last;
	logic [15:0] rd;
	logic [7:0] c;
	logic [1:0] ul;
	logic asel, byp, pend, bx, wl;
	initial
	begin
		{ul, asel, byp, pend, bx, wl} = 7'h00;
		last = 16'h0000;
	end
	assign rd = !asel ? mem[addr[7:0]] : addr[7:0] == 8'h02 ? {15'h0000, addr[16]}
		: addr[7:0] == 8'h03 ? 16'h0080 : MAKER_ID;
	// A released bus keeps no stale value.
	assign dq_in = dq_oe ? dq_out : (!ce_n && !oe_n) ? rd : ~last;
	// upper byte and high address ignored
	assign c = dq_out[7:0];
	always @(posedge sys_clk)
	begin
		last <= dq_in;
		wl <= !we_n;
		if (!ce_n && !we_n && !wl)
		begin
			wlog.push_back({addr, dq_out});
			if (pend)
			begin
				mem[addr[7:0]] <= dq_out;
				pend <= 1'b0;
			end
			else if (addr[10:0] == 11'h555 && c == 8'hAA)
				ul <= 2'h1;
			else if (ul == 2'h1 && addr[10:0] == 11'h2AA && c == 8'h55)
				ul <= 2'h2;
			else
			begin
				ul <= 2'h0;
				bx <= c == 8'h90;
				if (ul == 2'h2 && addr[10:0] == 11'h555)
				begin
					asel <= c == 8'h90;
					byp <= byp || c == 8'h20;
					pend <= c == 8'hA0;
				end
				else if (c == 8'hF0)
					asel <= 1'b0;
				else if (byp && c == 8'hA0)
					pend <= 1'b1;
				else if (bx && c == 8'h00)
				begin
					byp <= 1'b0;
					asel <= 1'b0;
				end
			end
		end
	end
endmodule : flash_dev_model
`default_nettype wire

// ### verification/tb.sv
/* Bench for the flash command decoder with a device model.
   Assumes a 20 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import flash_host_pkg::*;
	localparam logic [41:0] U1 = {UNLOCK_ADDR1, CMD_UNLOCK1};
	localparam logic [41:0] U2 = {UNLOCK_ADDR2, CMD_UNLOCK2};
	logic sys_clk, arst_n, req_valid, req_ready, wdata_valid, wdata_ready, rdv;
	logic done, refused, rd_valid, suspended, ce_n, we_n, oe_n, dq_oe;
	logic [15:0] wdata, rdata, dq_out, dq_in;
	logic [25:0] addr;
	logic [15:0] words[$];
	req_s req;
	mode_e mode;
	int errors, n_tests, cyc;
	flash_command_decoder dut (.sys_clk(sys_clk), .arst_n(arst_n), .req_valid(req_valid),
		.req(req), .req_ready(req_ready), .wdata_valid(wdata_valid), .wdata(wdata),
		.wdata_ready(wdata_ready), .done(done), .refused(refused), .rd_valid(rd_valid),
		.rdata(rdata), .mode(mode), .suspended(suspended), .flash_ce_n(ce_n),
		.flash_we_n(we_n), .flash_oe_n(oe_n), .flash_addr(addr), .flash_dq_out(dq_out),
		.flash_dq_oe(dq_oe), .flash_dq_in(dq_in));
	flash_dev_model dev (.sys_clk(sys_clk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
		.addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
	task automatic tally_and_finish();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// Handshakes are judged at the falling edge, where the design's outputs have settled.
	task automatic op(input op_e o, input logic [25:0] a, input logic rf,
		input logic [15:0] d = 16'h0000, input logic [4:0] c = 5'h00);
		int i;
		logic hs;
		i = 0;
		dev.wlog.delete();
		@(negedge sys_clk);
		req = '{o, a, d, c};
		req_valid = 1'b1;
		while (req_ready !== 1'b1)
			@(negedge sys_clk);
		@(negedge sys_clk);
		req_valid = 1'b0;
		repeat (3000)
		begin
			rdv = rd_valid;
			if (done || refused)
				break;
			wdata_valid = i < words.size();
			wdata = wdata_valid ? words[i] : 16'h0000;
			hs = wdata_valid && wdata_ready;
			@(negedge sys_clk);
			if (hs)
				i++;
		end
		wdata_valid = 1'b0;
		words.delete();
		check(refused, rf);
		check(rf ? dev.wlog.size() : 0, 0);
	endtask : op
	task automatic series(input logic [41:0] e[$]);
		check(dev.wlog.size(), e.size());
		foreach (e[j])
			check(dev.wlog[j], e[j]);
	endtask : series
	task automatic t_program_read();
		op(OP_SECURE_EXIT, ANY_ADDR, 1);
		op(OP_PROGRAM, 26'h0030004, 0, 16'hA5C3);
		series('{U1, U2, {UNLOCK_ADDR1, CMD_PROGRAM}, {26'h0030004, 16'hA5C3}});
		op(OP_READ, 26'h0030004, 0);
		check({dev.wlog.size(), rdv, rdata}, {32'h0, 1'b1, 16'hA5C3});
	endtask : t_program_read
	task automatic t_autoselect();
		op(OP_AUTOSELECT, 26'h0010002, 0);
		series('{U1, U2, {UNLOCK_ADDR1, CMD_AUTOSELECT}});
		check({rdv, rdata, mode}, {1'b1, 16'h0001, MODE_AUTOSELECT});
		op(OP_AUTOSELECT, 26'h0000002, 0);
		check(rdata, 16'h0000);
		op(OP_AUTOSELECT, 26'h0000003, 0);
		check(rdata[7], 1'b1);
		op(OP_PROGRAM, 26'h0030004, 1, 16'h0001);
		op(OP_CFI, CFI_ADDR, 0);
		series('{{CFI_ADDR, CMD_CFI}});
		op(OP_RESET, ANY_ADDR, 0);
		series('{{ANY_ADDR, CMD_RESET}});
		check(mode, MODE_ARRAY);
	endtask : t_autoselect
	task automatic t_buffer();
		words = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
		op(OP_BUF_PROGRAM, 26'h005001C, 0, 16'h0000, 5'h03);
		series('{U1, U2, {26'h0050000, CMD_BUF_LOAD}, {26'h0050000, 16'h0003},
			{26'h005001C, 16'h1111}, {26'h005001D, 16'h2222}, {26'h005001E, 16'h3333},
			{26'h005001F, 16'h4444}, {26'h0050000, CMD_BUF_CONFIRM}});
		words = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005};
		op(OP_BUF_PROGRAM, 26'h005001C, 1, 16'h0000, 5'h04);
		for (int j = 0; j < 32; j++)
			words.push_back(16'(j));
		op(OP_BUF_PROGRAM, 26'h0060000, 0, 16'h0000, 5'h1F);
		check(dev.wlog.size(), 37);
	endtask : t_buffer
	task automatic t_bypass();
		op(OP_BYPASS_PROGRAM, 26'h0070008, 1, 16'h0001);
		op(OP_BYPASS_ENTER, ANY_ADDR, 0);
		series('{U1, U2, {UNLOCK_ADDR1, CMD_BYPASS}});
		op(OP_BYPASS_PROGRAM, 26'h0070008, 0, 16'h5A5A);
		series('{{ANY_ADDR, CMD_PROGRAM}, {26'h0070008, 16'h5A5A}});
		op(OP_BYPASS_SECTOR_ERASE, 26'h0070008, 0);
		series('{{ANY_ADDR, CMD_ERASE_SETUP}, {26'h0070000, CMD_SECTOR_ERASE}});
		op(OP_BYPASS_CHIP_ERASE, ANY_ADDR, 0);
		series('{{ANY_ADDR, CMD_ERASE_SETUP}, {ANY_ADDR, CMD_CHIP_ERASE}});
		op(OP_CFI, CFI_ADDR, 1);
		op(OP_ABORT_RESET, ANY_ADDR, 0);
		series('{U1, U2, {UNLOCK_ADDR1, CMD_RESET}});
		op(OP_RESET, ANY_ADDR, 0);
		series('{{ANY_ADDR, CMD_EXIT}, {ANY_ADDR, CMD_EXIT_DATA}});
		op(OP_READ, 26'h0070008, 0);
		check({mode, rdata}, {MODE_ARRAY, 16'h5A5A});
	endtask : t_bypass
	task automatic t_erase();
		op(OP_SECTOR_ERASE, 26'h0080123, 0);
		series('{U1, U2, {UNLOCK_ADDR1, CMD_ERASE_SETUP}, U1, U2,
			{26'h0080000, CMD_SECTOR_ERASE}});
		op(OP_SUSPEND, ANY_ADDR, 0);
		series('{{ANY_ADDR, CMD_SUSPEND}});
		check(suspended, 1'b1);
		op(OP_PROGRAM, 26'h0090004, 0, 16'h0042);
		op(OP_READ, 26'h0090004, 0);
		check(rdata, 16'h0042);
		op(OP_CHIP_ERASE, ANY_ADDR, 1);
		op(OP_RESUME, ANY_ADDR, 0);
		series('{{ANY_ADDR, CMD_RESUME}});
		check(suspended, 1'b0);
		// resume refused when nothing is suspended
		op(OP_RESUME, ANY_ADDR, 1);
		op(OP_CHIP_ERASE, ANY_ADDR, 0);
		series('{U1, U2, {UNLOCK_ADDR1, CMD_ERASE_SETUP}, U1, U2,
			{UNLOCK_ADDR1, CMD_CHIP_ERASE}});
	endtask : t_erase
	task automatic t_secure();
		op(OP_SECURE_ENTER, ANY_ADDR, 0);
		series('{U1, U2, {UNLOCK_ADDR1, CMD_SECURE}});
		check(mode, MODE_SECURE);
		op(OP_SECURE_EXIT, ANY_ADDR, 0);
		series('{U1, U2, {UNLOCK_ADDR1, CMD_EXIT}, {ANY_ADDR, CMD_EXIT_DATA}});
		check(mode, MODE_ARRAY);
	endtask : t_secure
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// The ceiling is about twenty times the expected length of the run.
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			tally_and_finish();
		end
	end
	initial
	begin
		{arst_n, req_valid, wdata_valid, wdata, rdv} = '0;
		req = '0;
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		arst_n = 1'b1;
		t_program_read();
		t_autoselect();
		t_buffer();
		t_bypass();
		t_erase();
		t_secure();
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
